// ---- jump_subroutine_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module jump_subroutine_sequencer
  import jsub_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic single_step_btn,
  input wire logic load_address_btn,
  input wire logic run_btn,
  input wire logic halt_btn,
  input wire logic [WORD_W-1:0] switch_register,
  input wire logic [WORD_W-1:0] mem_rdata,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [WORD_W-1:0] mem_wdata,
  output logic mem_we,
  output logic [ADDR_W-1:0] pc,
  output logic indirect_lamp,
  output logic run_lamp
);
  decode_if dif();

  ////////////////////////////////////////////////////////////////////////
  // Panel synchronisers and press detection
  logic [3:0] btn_s1_ff;
  logic [3:0] btn_s2_ff;
  logic [3:0] btn_prev_ff;
  logic [WORD_W-1:0] sw_s1_ff;
  logic [WORD_W-1:0] sw_s2_ff;
  wire [3:0] btn_raw;
  wire [3:0] btn_press;

  assign btn_raw = {halt_btn, run_btn, load_address_btn, single_step_btn};
  // Edge taken on second stage only; first stage is metastability guard
  assign btn_press = btn_s2_ff & ~btn_prev_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      btn_s1_ff <= 4'h0;
      btn_s2_ff <= 4'h0;
      btn_prev_ff <= 4'h0;
      sw_s1_ff <= WORD_RST;
      sw_s2_ff <= WORD_RST;
    end
    else
    begin
      btn_s1_ff <= btn_raw;
      btn_s2_ff <= btn_s1_ff;
      btn_prev_ff <= btn_s2_ff;
      sw_s1_ff <= switch_register;
      sw_s2_ff <= sw_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  phase_e phase_ff;
  phase_e nxt_phase;
  logic [ADDR_W-1:0] pc_ff;
  logic [ADDR_W-1:0] nxt_pc;
  logic [ADDR_W-1:0] m_ff;
  logic [ADDR_W-1:0] nxt_m;
  logic [WORD_W-1:0] t_ff;
  logic [WORD_W-1:0] nxt_t;
  logic run_ff;
  logic nxt_run;
  logic jsub_pend_ff;
  logic nxt_jsub_pend;

  wire step_press;
  wire load_press;
  wire run_press;
  wire stop_press;
  wire phase_go;
  wire load_take;
  wire run_take;
  wire stop_take;
  wire phase_take;
  wire [ADDR_W-1:0] pc_inc;
  wire [ADDR_W-1:0] m_inc;
  wire [ADDR_W-1:0] word_addr;
  wire word_indirect;

  assign step_press = btn_press[0];
  assign load_press = btn_press[1];
  assign run_press = btn_press[2];
  assign stop_press = btn_press[3];
  // Stepping is ignored while running so a press never adds a phase
  assign phase_go = run_ff | step_press;
  // Refused presses fall through, so the write strobe must follow the same priority
  assign load_take = load_press && !run_ff;
  assign run_take = run_press && !run_ff;
  assign stop_take = stop_press && run_ff;
  assign phase_take = phase_go && !load_take && !run_take && !stop_take;
  assign pc_inc = pc_ff + ADDR_ONE;
  assign m_inc = m_ff + ADDR_ONE;
  assign word_addr = mem_rdata[ADDR_W-1:0];
  assign word_indirect = mem_rdata[IND_BIT];

  assign dif.instr = mem_rdata;
  assign dif.here = m_ff;

  jump_decoder u_dec (
    .d(dif)
  );

  always_comb
  begin
    nxt_phase = phase_ff;
    nxt_pc = pc_ff;
    nxt_m = m_ff;
    nxt_t = t_ff;
    nxt_run = run_ff;
    nxt_jsub_pend = jsub_pend_ff;
    if (load_take)
    begin
      nxt_pc = sw_s2_ff[ADDR_W-1:0];
      nxt_m = sw_s2_ff[ADDR_W-1:0];
      nxt_phase = ST_FETCH;
      nxt_jsub_pend = 1'b0;
    end
    else if (run_take)
    begin
      nxt_run = 1'b1;
    end
    else if (stop_take)
    begin
      nxt_run = 1'b0;
    end
    else if (phase_go)
    begin
      case (phase_ff)
        ST_FETCH:
        begin
          nxt_t = mem_rdata;
          if ((dif.is_jump || dif.is_jsub) && dif.indirect)
          begin
            nxt_m = dif.target;
            nxt_jsub_pend = dif.is_jsub;
            nxt_phase = ST_INDIRECT;
          end
          else if (dif.is_jump)
          begin
            nxt_pc = dif.target;
            nxt_m = dif.target;
          end
          else if (dif.is_jsub)
          begin
            nxt_m = dif.target;
            nxt_t = {1'b0, pc_inc};
            nxt_phase = ST_STORE;
          end
          else
          begin
            nxt_pc = pc_inc;
            nxt_m = pc_inc;
            if (dif.is_halt)
            begin
              nxt_run = 1'b0;
            end
          end
        end
        ST_INDIRECT:
        begin
          nxt_t = mem_rdata;
          nxt_m = word_addr;
          if (word_indirect)
          begin
            // Chained address words: stay and follow the next level
            nxt_phase = ST_INDIRECT;
          end
          else if (jsub_pend_ff)
          begin
            nxt_t = {1'b0, pc_inc};
            nxt_jsub_pend = 1'b0;
            nxt_phase = ST_STORE;
          end
          else
          begin
            nxt_pc = word_addr;
            nxt_phase = ST_FETCH;
          end
        end
        ST_STORE:
        begin
          nxt_pc = m_inc;
          nxt_m = m_inc;
          nxt_phase = ST_FETCH;
        end
        default:
        begin
          nxt_phase = ST_FETCH;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase_ff <= ST_FETCH;
      pc_ff <= ADDR_RST;
      m_ff <= ADDR_RST;
      t_ff <= WORD_RST;
      run_ff <= 1'b0;
      jsub_pend_ff <= 1'b0;
    end
    else
    begin
      phase_ff <= nxt_phase;
      pc_ff <= nxt_pc;
      m_ff <= nxt_m;
      t_ff <= nxt_t;
      run_ff <= nxt_run;
      jsub_pend_ff <= nxt_jsub_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Return word was captured in T during fetch or the last indirect phase, so the write needs no adder here
  assign mem_we = phase_take && (phase_ff == ST_STORE);
  assign mem_wdata = t_ff;
  assign mem_addr = m_ff;
  assign pc = pc_ff;
  assign indirect_lamp = (phase_ff == ST_INDIRECT);
  assign run_lamp = run_ff;
endmodule
`default_nettype wire

// ---- jsub_pkg.sv ----
package jsub_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 15;
  localparam int OFS_W = 10;
  localparam int PAGE_W = ADDR_W - OFS_W;
  localparam int IND_BIT = 15;
  localparam int ZC_BIT = 10;
  localparam int OP_LSB = 11;
  localparam logic [3:0] OP_JUMP = 4'h5;
  localparam logic [3:0] OP_JSUB = 4'h3;
  localparam logic [WORD_W-1:0] HALT_MASK = 16'hffc0;
  localparam logic [WORD_W-1:0] HALT_CODE = 16'h8400;
  localparam logic [PAGE_W-1:0] PAGE_ZERO = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 15'h0001;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_INDIRECT = 3'b010,
    ST_STORE = 3'b100
  } phase_e;
endpackage

// ---- decode_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface decode_if;
  import jsub_pkg::*;
  logic [WORD_W-1:0] instr;
  logic [ADDR_W-1:0] here;
  logic [ADDR_W-1:0] target;
  logic is_jump;
  logic is_jsub;
  logic is_halt;
  logic indirect;
  modport seq (output instr, output here, input target, input is_jump, input is_jsub,
    input is_halt, input indirect);
  modport dec (input instr, input here, output target, output is_jump, output is_jsub,
    output is_halt, output indirect);
endinterface
`default_nettype wire

// ---- jump_decoder.sv ----
`timescale 1ns/10ps
`default_nettype none
module jump_decoder
  import jsub_pkg::*;
(
  decode_if.dec d
);
  wire [3:0] opcode;
  wire current_page;
  wire [PAGE_W-1:0] page_sel;

  assign opcode = d.instr[OP_LSB+3:OP_LSB];
  assign current_page = d.instr[ZC_BIT];
  // Only two pages are reachable directly; anything else needs an address word
  assign page_sel = current_page ? d.here[ADDR_W-1:OFS_W] : PAGE_ZERO;
  assign d.target = {page_sel, d.instr[OFS_W-1:0]};
  assign d.is_jump = (opcode == OP_JUMP);
  assign d.is_jsub = (opcode == OP_JSUB);
  assign d.is_halt = ((d.instr & HALT_MASK) == HALT_CODE);
  assign d.indirect = d.instr[IND_BIT];
endmodule
`default_nettype wire

// ---- core_memory.sv ----
`timescale 1ns/10ps
`default_nettype none
module core_memory
  import jsub_pkg::*;
(
  input wire logic clk,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [WORD_W-1:0] wdata,
  input wire logic we,
  output logic [WORD_W-1:0] rdata
);
  logic [WORD_W-1:0] words [2**ADDR_W];
  // Cleared cells read as no-op words, never as unknowns
  initial
  begin
    foreach (words[i]) words[i] = WORD_RST;
  end
  // Async read, the design samples in the same cycle
  assign rdata = words[addr];
  always @(posedge clk)
  begin
    if (we) words[addr] <= wdata;
  end
endmodule
`default_nettype wire

// ---- jump_subroutine_sequencer_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module seq_chk
  import jsub_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic single_step_btn,
  input wire logic load_address_btn,
  input wire logic run_btn,
  input wire logic [WORD_W-1:0] mem_rdata,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [WORD_W-1:0] mem_wdata,
  input wire logic mem_we,
  input wire logic [ADDR_W-1:0] pc,
  input wire logic indirect_lamp,
  input wire logic run_lamp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Free-run only: a halted store phase looks like fetch
  wire logic fetch = run_lamp && !indirect_lamp && !mem_we;
  wire logic [3:0] op = mem_rdata[14:11];
  wire logic xfer = op == OP_JUMP || op == OP_JSUB;
  wire logic direct = fetch && !mem_rdata[IND_BIT];
  wire logic [PAGE_W-1:0] pg = mem_rdata[ZC_BIT] ? mem_addr[14:10] : PAGE_ZERO;
  wire logic [ADDR_W-1:0] tgt = {pg, mem_rdata[9:0]};
  wire logic plain = fetch && !xfer && (mem_rdata & HALT_MASK) != HALT_CODE;
  wire logic idle = !run_lamp && !single_step_btn && !run_btn && !load_address_btn;
  sequence jsub_fetch;
    direct && op == OP_JSUB;
  endsequence
  sequence store_cycle;
    mem_we;
  endsequence
  ////////////////////////////////////////
  seq_step_a: assert property (plain |=> pc == $past(pc) + ADDR_ONE)
    else $error("pc did not advance by one");
  jump_direct_a: assert property (direct && op == OP_JUMP |=> pc == $past(tgt))
    else $error("direct jump target wrong");
  jsub_fetch_a: assert property (jsub_fetch |=> mem_we && $stable(pc))
    else $error("subroutine fetch phase wrong");
  store_write_a: assert property (store_cycle |-> mem_wdata == {1'b0, pc + ADDR_ONE})
    else $error("return address wrong");
  store_jump_a: assert property (store_cycle |=> pc == $past(mem_addr) + ADDR_ONE)
    else $error("store phase did not transfer");
  ind_lamp_a: assert property (fetch && mem_rdata[IND_BIT] && xfer |=> indirect_lamp)
    else $error("indirect lamp not lit");
  ind_resolve_a: assert property (run_lamp && indirect_lamp && !mem_rdata[IND_BIT]
    |=> mem_addr == $past(mem_rdata[ADDR_W-1:0])) else $error("indirect word not used");
  halt_hold_a: assert property (idle [*4] |=> $stable(pc))
    else $error("pc moved while halted");
endmodule
bind jump_subroutine_sequencer seq_chk seq_chk_inst (.clk(clk), .rst(rst),
  .single_step_btn(single_step_btn), .load_address_btn(load_address_btn), .run_btn(run_btn),
  .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .pc(pc),
  .indirect_lamp(indirect_lamp), .run_lamp(run_lamp));
`default_nettype wire

// ---- test_jump_subroutine_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_jump_subroutine_sequencer;
  import jsub_pkg::*;
  typedef struct packed {logic [ADDR_W-1:0] pc; logic [ADDR_W-1:0] ma; logic lamp;} step_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] btn = 4'h0;
  logic [WORD_W-1:0] sw = WORD_RST;
  logic [WORD_W-1:0] rd, wd;
  logic [ADDR_W-1:0] ma, pc;
  logic we, il, rl;
  int fail_count = 0;
  int n_compared = 0;
  step_s rows [12] = '{'{15'h441, 15'h441, 1'b0}, '{15'h480, 15'h480, 1'b0},
    '{15'h481, 15'h481, 1'b0}, '{15'h482, 15'h482, 1'b0}, '{15'h482, 15'h5fb, 1'b0},
    '{15'h5fc, 15'h5fc, 1'b0}, '{15'h5fd, 15'h5fd, 1'b0}, '{15'h5fe, 15'h5fe, 1'b0},
    '{15'h5ff, 15'h5ff, 1'b0}, '{15'h5ff, 15'h5fb, 1'b1}, '{15'h483, 15'h483, 1'b0},
    '{15'h484, 15'h484, 1'b0}};
  jump_subroutine_sequencer jump_subroutine_sequencer_inst (.clk(clk), .rst(rst),
    .single_step_btn(btn[0]), .load_address_btn(btn[1]), .run_btn(btn[2]), .halt_btn(btn[3]),
    .switch_register(sw), .mem_rdata(rd), .mem_addr(ma), .mem_wdata(wd), .mem_we(we), .pc(pc),
    .indirect_lamp(il), .run_lamp(rl));
  core_memory core_memory_inst (.clk(clk), .addr(ma), .wdata(wd), .we(we), .rdata(rd));
  ////////////////////////////////////////
  task check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Held five edges: two sync stages plus edge detect need three
  task press(input int b);
    @(posedge clk);
    btn[b] <= 1'b1;
    repeat (5) @(posedge clk);
    btn[b] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task run_to_halt(input logic [ADDR_W-1:0] exp_pc, input logic [WORD_W-1:0] ret);
    core_memory_inst.words[15'h5fb] = WORD_RST;
    press(2);
    for (int k = 0; k < 60 && rl !== 1'b0; k++) @(posedge clk);
    check({1'b0, pc}, {1'b0, exp_pc});
    check(core_memory_inst.words[15'h5fb], ret);
  endtask
  task end_of_test;
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    fail_count++;
    end_of_test;
  end
  initial
  begin
    // Wait past time zero so the memory's own clearing cannot wipe the program
    @(posedge clk);
    core_memory_inst.words[15'h441] = 16'h2c80;
    core_memory_inst.words[15'h482] = 16'h1dfb;
    core_memory_inst.words[15'h483] = HALT_CODE;
    core_memory_inst.words[15'h484] = 16'h9810;
    core_memory_inst.words[15'h485] = HALT_CODE;
    core_memory_inst.words[15'h5ff] = 16'hadfb;
    core_memory_inst.words[15'h010] = 16'h05fb;
    core_memory_inst.words[15'h486] = 16'h2c86;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({ma, rl}, WORD_RST);
    check({pc, il}, WORD_RST);
    sw <= 16'h0440;
    press(1);
    check({1'b0, pc}, 16'h0440);
    foreach (rows[i])
    begin
      press(0);
      check({1'b0, pc}, {1'b0, rows[i].pc});
      check({1'b0, ma}, {1'b0, rows[i].ma});
      check({15'h0000, il}, {15'h0000, rows[i].lamp});
    end
    check(core_memory_inst.words[15'h5fb], 16'h0483);
    press(1);
    run_to_halt(15'h484, 16'h0483);
    run_to_halt(15'h486, 16'h0485);
    // Jump to self keeps running; load is refused, stop ends it
    press(2);
    press(1);
    check({15'h0000, rl}, 16'h0001);
    check({1'b0, pc}, 16'h0486);
    press(3);
    check({15'h0000, rl}, WORD_RST);
    check({1'b0, pc}, 16'h0486);
    end_of_test;
  end
endmodule
`default_nettype wire
